// ### tone_lookup_defines.svh
// constants of the pixel tone lookup: offsets, resets, counts
// assumes byte addressing on a 32-bit apb bus
`ifndef TONE_LOOKUP_DEFINES_SVH
`define TONE_LOOKUP_DEFINES_SVH

// ==========================================================
// widths and limits
`define PIX_MAX 12'hfff
`define THR_FULL 13'h1000
`define DIV_LAST 5'h0b

// ==========================================================
// register byte offsets
`define OFS_ENABLE 8'h00
`define OFS_SHAPE 8'h04
`define OFS_THRESHOLD 8'h08
`define OFS_KNEE_SEL 8'h0c
`define OFS_KNEE_IN 8'h10
`define OFS_KNEE_OUT 8'h14
`define OFS_BUILD 8'h18
`define OFS_ENTRY_SEL 8'h1c
`define OFS_ENTRY_VAL 8'h20
`define OFS_PERSIST 8'h24
`define OFS_STATUS 8'h28
`define OFS_SAVED_VAL 8'h2c

// ==========================================================
// reset values
`define RST_ENABLE 1'h0
`define RST_SHAPE 3'h0
`define RST_THRESHOLD 13'h07ff
`define RST_KNEE_SEL 3'h1
`define RST_KNEE_STEP 12'h02aa
`define RST_ENTRY_SEL 12'h000

`endif

// ### tone_lookup_pkg.sv
// types shared by the pixel tone lookup modules
// assumes the constants header is included by each module
package tone_lookup_pkg;

   // ==========================================================
   // curve shapes, as coded in the shape register
   typedef enum logic [2:0]
   {
      LINEAR_MODE = 3'h0,
      REVERSE_MODE = 3'h1,
      BINARY_MODE = 3'h2,
      KNEE_CURVE_MODE = 3'h3,
      FREE_TABLE_MODE = 3'h4
   } curve_shape_t;

   typedef logic [4:0][11:0] knee_arr_t;

   // ==========================================================
   // sequencer states, gray from B_IDLE through B_WRITE; B_WRITE to B_SETUP flips both bits
   typedef enum logic [1:0]
   {
      B_IDLE = 2'b00,
      B_SETUP = 2'b01,
      B_DIV = 2'b11,
      B_WRITE = 2'b10
   } build_state_t;

   typedef enum logic {S_IDLE = 1'b0, S_COPY = 1'b1} save_state_t;

endpackage

// ### table_port_if.sv
// table access port between the lookup top and its sequencers
// assumes one clock domain; the top owns the table array
`timescale 1ns/100ps
`default_nettype none
interface table_port_if;
   logic wr_en;
   logic [11:0] wr_addr;
   logic [11:0] wr_data;
   logic [11:0] rd_addr;
   logic [11:0] rd_data;
   modport writer(output wr_en, output wr_addr, output wr_data);
   modport reader(output rd_addr, input rd_data);
   modport owner(input wr_en, input wr_addr, input wr_data,
      input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### knee_builder.sv
// rebuilds the whole table from five knees by straight lines
// assumes knees ascend in input level and stay put while busy
`timescale 1ns/100ps
`default_nettype none
module knee_builder
   import tone_lookup_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire knee_arr_t knee_in,
   input wire knee_arr_t knee_out,
   output logic busy,
   table_port_if.writer tport
);
`include "tone_lookup_defines.svh"

   build_state_t state_reg, state_next;
   logic [11:0] x_reg, x_next;
   logic [4:0] step_reg, step_next;
   logic [12:0] rem_reg, rem_next;
   logic [23:0] quo_reg, quo_next;
   logic [6:0][11:0] pin, pout;
   logic [2:0] seg;
   logic [11:0] xa, ya, yb, dx, dy;
   logic down;
   logic [23:0] num;
   logic [12:0] rem_sh;

   // ==========================================================
   // segment search; ends pinned at black and full scale
   always_comb
   begin
      pin = {`PIX_MAX, knee_in, 12'h000};
      pout = {`PIX_MAX, knee_out, 12'h000};
      seg = 3'h6;
      for (int k = 5; k >= 1; k--)
         if (x_reg <= pin[k])
            seg = 3'(k);
      xa = pin[seg - 3'h1];
      ya = pout[seg - 3'h1];
      yb = pout[seg];
      dx = pin[seg] - xa;
      down = yb < ya;
      dy = down ? ya - yb : yb - ya;
      num = 24'(x_reg - xa) * 24'(dy);
      rem_sh = {rem_reg[11:0], quo_reg[23]};
   end

   // ==========================================================
   // one entry per pass: setup, 12 divide steps, write
   always_comb
   begin
      state_next = state_reg;
      x_next = x_reg;
      step_next = step_reg;
      rem_next = rem_reg;
      quo_next = quo_reg;
      unique case (state_reg)
         B_IDLE:
            if (start)
            begin
               x_next = 12'h000;
               state_next = B_SETUP;
            end
         B_SETUP:
         begin
            // quotient fits 12 bits, so the high half is already below
            // dx: 12 steps suffice, which halves the divide steps
            rem_next = {1'b0, num[23:12]};
            step_next = 5'h00;
            // flat step in input: jump straight to the upper knee
            quo_next = (dx == 12'h000) ? 24'(dy) : {num[11:0], 12'h000};
            state_next = (dx == 12'h000) ? B_WRITE : B_DIV;
         end
         B_DIV:
         begin
            // restoring divide, exact and truncating
            if (rem_sh >= {1'b0, dx})
            begin
               rem_next = rem_sh - {1'b0, dx};
               quo_next = {quo_reg[22:0], 1'b1};
            end
            else
            begin
               rem_next = rem_sh;
               quo_next = {quo_reg[22:0], 1'b0};
            end
            step_next = step_reg + 5'h01;
            if (step_reg == `DIV_LAST)
               state_next = B_WRITE;
         end
         B_WRITE:
            if (x_reg == `PIX_MAX)
               state_next = B_IDLE;
            else
            begin
               x_next = x_reg + 12'h001;
               state_next = B_SETUP;
            end
      endcase
   end

   // ==========================================================
   // sequencer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= B_IDLE;
         x_reg <= 12'h000;
         step_reg <= 5'h00;
         rem_reg <= 13'h0000;
         quo_reg <= 24'h00_0000;
      end
      else
      begin
         state_reg <= state_next;
         x_reg <= x_next;
         step_reg <= step_next;
         rem_reg <= rem_next;
         quo_reg <= quo_next;
      end
   end

   // straight line from the lower knee
   assign tport.wr_en = (state_reg == B_WRITE);
   assign tport.wr_addr = x_reg;
   assign tport.wr_data = down ? ya - quo_reg[11:0] : ya + quo_reg[11:0];
   assign busy = (state_reg != B_IDLE);

   // ==========================================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence div_run;
      (state_reg == B_DIV) [*8];
   endsequence

   interp_range_a:
   assert property (tport.wr_en |-> (down ? (tport.wr_data <= ya &&
      tport.wr_data >= yb) : (tport.wr_data >= ya && tport.wr_data <= yb)))
      else $error("interpolated value outside its segment");

   divide_length_a:
   assert property (state_reg == B_SETUP && dx != 12'h000 |=>
      div_run ##5 (state_reg == B_WRITE))
      else $error("divide did not take 12 steps");

   build_sweep_a:
   assert property (state_reg == B_IDLE && start |=>
      busy && x_reg == 12'h000 && state_reg == B_SETUP)
      else $error("build did not start from entry zero");

   build_end_a:
   assert property (tport.wr_en && x_reg == `PIX_MAX |=> !busy)
      else $error("build did not stop after the last entry");
endmodule
`default_nettype wire

// ### table_saver.sv
// copies the live table into the persistent copy on command
// assumes the table read port answers in the same cycle
`timescale 1ns/100ps
`default_nettype none
module table_saver
   import tone_lookup_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [11:0] saved_addr,
   output logic [11:0] saved_data,
   output logic busy,
   table_port_if.reader tport
);
`include "tone_lookup_defines.svh"

   save_state_t state_reg, state_next;
   logic [11:0] addr_reg, addr_next;
   // persistent copy; not cleared by reset on purpose
   logic [11:0] store [4096];

   // ==========================================================
   // one entry per cycle, 4096 cycles in all
   always_comb
   begin
      state_next = state_reg;
      addr_next = addr_reg;
      unique case (state_reg)
         S_IDLE:
            if (start)
            begin
               addr_next = 12'h000;
               state_next = S_COPY;
            end
         S_COPY:
         begin
            addr_next = addr_reg + 12'h001;
            if (addr_reg == `PIX_MAX)
               state_next = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= S_IDLE;
         addr_reg <= 12'h000;
      end
      else
      begin
         state_reg <= state_next;
         addr_reg <= addr_next;
      end
   end

   // copy port of the persistent store
   always_ff @(posedge pclk)
   begin
      if (state_reg == S_COPY)
         store[addr_reg] <= tport.rd_data;
   end

   assign tport.rd_addr = addr_reg;
   assign saved_data = store[saved_addr];
   assign busy = (state_reg == S_COPY);

   // ==========================================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   save_copy_a:
   assert property (busy |=> store[$past(addr_reg)] == $past(tport.rd_data))
      else $error("entry not copied to persistent store");

   save_start_a:
   assert property (!busy && start |=> busy && addr_reg == 12'h000)
      else $error("save did not start from entry zero");
endmodule
`default_nettype wire

// ### pixel_tone_lookup.sv
// pixel tone lookup: apb registers, 4096-entry table, pixel path
// assumes pixels and the bus share pclk; one pixel a cycle at most
//
// How it works
// - lookup enable 0 passes pixels unchanged; 1 applies the chosen curve
// - shape 0 linear, 1 reversed, 2 binary, 3 knee, 4 free table
// - pixels, table entries and knee levels are 12 bits wide; the threshold is 13
// - binary mode compares against a threshold 0..4096, reset 2047
// - five knees, index 1 to 5, each with input and output level
// - between adjacent knees the output follows a straight line
// - software builds after writing knees; build refills the whole table
// - entry select picks a code; value write stores its output
// - save command copies the live table into persistent storage
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pixel_tone_lookup
   import tone_lookup_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pix_in_valid,
   input wire logic [11:0] pix_in_data,
   output logic pix_out_valid,
   output logic [11:0] pix_out_data
);
`include "tone_lookup_defines.svh"

   logic enable_reg, enable_next;
   logic [2:0] shape_reg, shape_next;
   logic [12:0] thr_reg, thr_next;
   logic [2:0] knee_sel_reg, knee_sel_next;
   knee_arr_t knee_in_reg, knee_in_next;
   knee_arr_t knee_out_reg, knee_out_next;
   logic [11:0] entry_sel_reg, entry_sel_next;
   logic build_go_reg, build_go_next;
   logic save_go_reg, save_go_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic sw_we;
   logic build_busy, save_busy, busy;
   logic knee_ok;
   logic [2:0] knee_idx;
   logic decode_phase, commit;
   logic [11:0] saved_data;
   logic [11:0] pix_reg, pix_next;
   logic pix_valid_reg;
   // live table; contents undefined until written or built
   logic [11:0] lut_mem [4096];

   table_port_if tport ();

   // ==========================================================
   // sequencers sharing the table
   knee_builder builder_u (
      .pclk(pclk),
      .presetn(presetn),
      .start(build_go_reg),
      .knee_in(knee_in_reg),
      .knee_out(knee_out_reg),
      .busy(build_busy),
      .tport(tport.writer)
   );

   table_saver saver_u (
      .pclk(pclk),
      .presetn(presetn),
      .start(save_go_reg),
      .saved_addr(entry_sel_reg),
      .saved_data(saved_data),
      .busy(save_busy),
      .tport(tport.reader)
   );

   assign busy = build_busy | save_busy;
   assign tport.rd_data = lut_mem[tport.rd_addr];
   assign knee_ok = knee_sel_reg >= 3'h1 && knee_sel_reg <= 3'h5;
   assign knee_idx = knee_sel_reg - 3'h1;
   // one wait state: answer computed in the first access cycle
   assign decode_phase = psel & penable & ~pready_reg;
   assign commit = psel & penable & pready_reg;

   // ==========================================================
   // register file: writes land on the completing edge
   always_comb
   begin
      enable_next = enable_reg;
      shape_next = shape_reg;
      thr_next = thr_reg;
      knee_sel_next = knee_sel_reg;
      knee_in_next = knee_in_reg;
      knee_out_next = knee_out_reg;
      entry_sel_next = entry_sel_reg;
      build_go_next = 1'b0;
      save_go_next = 1'b0;
      sw_we = 1'b0;
      prdata_next = prdata_reg;
      pready_next = decode_phase;
      pslverr_next = 1'b0;
      if (decode_phase)
      begin
         prdata_next = 32'h0000_0000;
         case (paddr)
            `OFS_ENABLE: prdata_next = 32'(enable_reg);
            `OFS_SHAPE: prdata_next = 32'(shape_reg);
            `OFS_THRESHOLD: prdata_next = 32'(thr_reg);
            `OFS_KNEE_SEL: prdata_next = 32'(knee_sel_reg);
            `OFS_KNEE_IN:
               if (knee_ok)
                  prdata_next = 32'(knee_in_reg[knee_idx]);
            `OFS_KNEE_OUT:
               if (knee_ok)
                  prdata_next = 32'(knee_out_reg[knee_idx]);
            `OFS_ENTRY_SEL: prdata_next = 32'(entry_sel_reg);
            `OFS_ENTRY_VAL: prdata_next = 32'(lut_mem[entry_sel_reg]);
            `OFS_STATUS: prdata_next = {30'h0, save_busy, build_busy};
            `OFS_SAVED_VAL: prdata_next = 32'(saved_data);
            `OFS_BUILD, `OFS_PERSIST:
               pslverr_next = ~pwrite | busy;
            default: pslverr_next = 1'b1;
         endcase
         // table writes refused while a sequencer owns the table
         if (pwrite && paddr == `OFS_ENTRY_VAL && busy)
            pslverr_next = 1'b1;
         if (pwrite && (paddr == `OFS_STATUS || paddr == `OFS_SAVED_VAL))
            pslverr_next = 1'b1;
      end
      if (commit && pwrite)
      begin
         case (paddr)
            `OFS_ENABLE: enable_next = pwdata[0];
            `OFS_SHAPE: shape_next = pwdata[2:0];
            `OFS_THRESHOLD:
               // values past 4096 saturate at 4096
               thr_next = (pwdata > 32'(`THR_FULL)) ? `THR_FULL
                  : pwdata[12:0];
            `OFS_KNEE_SEL: knee_sel_next = pwdata[2:0];
            `OFS_KNEE_IN:
               if (knee_ok)
                  knee_in_next[knee_idx] = pwdata[11:0];
            `OFS_KNEE_OUT:
               if (knee_ok)
                  knee_out_next[knee_idx] = pwdata[11:0];
            `OFS_BUILD: build_go_next = pwdata[0] & ~busy;
            `OFS_ENTRY_SEL: entry_sel_next = pwdata[11:0];
            `OFS_ENTRY_VAL: sw_we = ~busy;
            `OFS_PERSIST: save_go_next = pwdata[0] & ~busy;
            default: sw_we = 1'b0;
         endcase
      end
   end

   // ==========================================================
   // register file flip-flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enable_reg <= `RST_ENABLE;
         shape_reg <= `RST_SHAPE;
         thr_reg <= `RST_THRESHOLD;
         knee_sel_reg <= `RST_KNEE_SEL;
         for (int k = 0; k < 5; k++)
         begin
            knee_in_reg[k] <= 12'(k + 1) * `RST_KNEE_STEP;
            knee_out_reg[k] <= 12'(k + 1) * `RST_KNEE_STEP;
         end
         entry_sel_reg <= `RST_ENTRY_SEL;
         build_go_reg <= 1'b0;
         save_go_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         enable_reg <= enable_next;
         shape_reg <= shape_next;
         thr_reg <= thr_next;
         knee_sel_reg <= knee_sel_next;
         knee_in_reg <= knee_in_next;
         knee_out_reg <= knee_out_next;
         entry_sel_reg <= entry_sel_next;
         build_go_reg <= build_go_next;
         save_go_reg <= save_go_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // ==========================================================
   // table write port: builder first, software when idle
   always_ff @(posedge pclk)
   begin
      if (tport.wr_en)
         lut_mem[tport.wr_addr] <= tport.wr_data;
      else if (sw_we)
         lut_mem[entry_sel_reg] <= pwdata[11:0];
   end

   // ==========================================================
   // pixel path, one cycle of latency, 12 bits throughout
   always_comb
   begin
      pix_next = pix_in_data;
      if (enable_reg)
      begin
         case (shape_reg)
            LINEAR_MODE: pix_next = pix_in_data;
            REVERSE_MODE: pix_next = `PIX_MAX - pix_in_data;
            BINARY_MODE:
               pix_next = ({1'b0, pix_in_data} >= thr_reg) ? `PIX_MAX
                  : 12'h000;
            KNEE_CURVE_MODE, FREE_TABLE_MODE:
               pix_next = lut_mem[pix_in_data];
            default: pix_next = pix_in_data;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pix_reg <= 12'h000;
         pix_valid_reg <= 1'b0;
      end
      else
      begin
         pix_valid_reg <= pix_in_valid;
         if (pix_in_valid)
            pix_reg <= pix_next;
      end
   end

   assign pix_out_data = pix_reg;
   assign pix_out_valid = pix_valid_reg;

   // ==========================================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence pix_taken(logic [2:0] mode);
      pix_in_valid && enable_reg && shape_reg == mode;
   endsequence

   bypass_path_a:
   assert property (pix_in_valid && !enable_reg |=>
      pix_out_valid && pix_out_data == $past(pix_in_data))
      else $error("disabled lookup altered a pixel");

   linear_curve_a:
   assert property (pix_taken(LINEAR_MODE) |=>
      pix_out_data == $past(pix_in_data))
      else $error("linear curve altered a pixel");

   reverse_curve_a:
   assert property (pix_taken(REVERSE_MODE) |=>
      pix_out_data == 12'hfff - $past(pix_in_data))
      else $error("reversed curve wrong");

   binary_curve_a:
   assert property (pix_taken(BINARY_MODE) |=> pix_out_data ==
      (({1'b0, $past(pix_in_data)} >= $past(thr_reg)) ? 12'hfff : 12'h000))
      else $error("binary curve wrong");

   table_curve_a:
   assert property (pix_taken(FREE_TABLE_MODE) ##0 (!tport.wr_en && !sw_we)
      |=> pix_out_data == lut_mem[$past(pix_in_data)])
      else $error("table curve wrong");

   entry_write_a:
   assert property (sw_we |=> lut_mem[$past(entry_sel_reg)] ==
      $past(pwdata[11:0]))
      else $error("table entry not stored");

   knee_store_a:
   assert property (commit && pwrite && paddr == `OFS_KNEE_OUT && knee_ok
      |=> knee_out_reg[$past(knee_idx)] == $past(pwdata[11:0]))
      else $error("knee output level not stored");

   threshold_range_a:
   assert property (thr_reg <= 13'h1000)
      else $error("threshold beyond 4096");

   build_trigger_a:
   assert property (commit && pwrite && paddr == `OFS_BUILD && pwdata[0]
      && !busy |=> ##1 build_busy)
      else $error("build command ignored");

   apb_wait_a:
   assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not after exactly one wait state");
endmodule
`default_nettype wire

// ### pixel_stream_model.sv
// pixel source and sink facing the lookup's stream ports
// assumes the mapped pixel comes back exactly one cycle later
`timescale 1ns/100ps
`default_nettype none
module pixel_stream_model
(
   input wire logic pclk,
   input wire logic out_valid,
   input wire logic [11:0] out_data,
   output logic in_valid,
   output logic [11:0] in_data
);
   // ==========================================================
   // stream idle from time zero
   initial
   begin
      in_valid = 1'b0;
      in_data = 12'h000;
   end

   // one pixel out, then the mapped value and its strobe back
   task automatic send(input logic [11:0] x, output logic [11:0] y,
      output logic v);
      @(posedge pclk);
      in_valid <= 1'b1;
      in_data <= x;
      @(posedge pclk);
      in_valid <= 1'b0;
      in_data <= ~x; // no stale value between pixels
      @(posedge pclk);
      y = out_data;
      v = out_valid;
   endtask
endmodule
`default_nettype wire

// ### pixel_tone_lookup_test.sv
// self-checking bench of the pixel tone lookup over apb
// assumes the design's constants header and package are compiled
`timescale 1ns/100ps
`default_nettype none
`include "tone_lookup_defines.svh"
module pixel_tone_lookup_test;
   import tone_lookup_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pix_in_valid;
   logic [11:0] pix_in_data;
   logic pix_out_valid;
   logic [11:0] pix_out_data;
   logic [31:0] r;
   logic e;
   logic [11:0] y;
   logic v;
   int n;
   int polls;
   int mismatches = 0;
   int samples_checked = 0;

   // ==========================================================
   // clock, design and stream partner
   always #4 pclk = ~pclk;

   pixel_tone_lookup i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pix_in_valid(pix_in_valid),
      .pix_in_data(pix_in_data), .pix_out_valid(pix_out_valid),
      .pix_out_data(pix_out_data));

   pixel_stream_model i_pix (.pclk(pclk), .out_valid(pix_out_valid),
      .out_data(pix_out_data), .in_valid(pix_in_valid),
      .in_data(pix_in_data));

   // ==========================================================
   // comparison and closing
   task chk(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // apb transfer; request held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++n < 20);
      chk(pready, 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk(e, 1'b0);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, x);
   endtask

   task bad(input logic w, input logic [7:0] a);
      apb(w, a, 32'h0000_0000);
      chk(e, 1'b1);
   endtask

   // poll status until both sequencers are idle, bounded
   task idle(input int lim);
      polls = 0;
      do
         apb(1'b0, `OFS_STATUS, 32'h0000_0000);
      while (r !== 32'h0000_0000 && ++polls < lim);
      chk(r, 32'h0000_0000);
   endtask

   task px(input logic [11:0] x, input logic [11:0] q);
      i_pix.send(x, y, v);
      chk(v, 1'b1);
      chk(y, q);
   endtask

   // ==========================================================
   // watchdog: the knee build, 14 cycles an entry, dominates the run
   initial
   begin
      repeat (80000) @(posedge pclk);
      mismatches++;
      give_verdict;
   end

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFS_ENABLE, 32'h0000_0000);
      rd(`OFS_SHAPE, 32'h0000_0000);
      rd(`OFS_THRESHOLD, 32'h0000_07ff);
      rd(`OFS_KNEE_SEL, 32'h0000_0001);
      // reversed shape chosen but lookup still off
      wr(`OFS_SHAPE, 32'h0000_0001);
      px(12'h9a5, 12'h9a5);
      wr(`OFS_ENABLE, 32'h0000_0001);
      rd(`OFS_ENABLE, 32'h0000_0001);
      px(12'h9a5, 12'h65a);
      wr(`OFS_SHAPE, 32'h0000_0000);
      px(12'h3c7, 12'h3c7);
      // threshold boundary: equal maps to full scale
      wr(`OFS_THRESHOLD, 32'h0000_0100);
      wr(`OFS_SHAPE, 32'h0000_0002);
      px(12'h100, 12'hfff);
      px(12'h0ff, 12'h000);
      wr(`OFS_THRESHOLD, 32'h0000_1fff);
      rd(`OFS_THRESHOLD, 32'h0000_1000);
      px(12'hfff, 12'h000);
      wr(`OFS_SHAPE, 32'h0000_0005);
      px(12'h456, 12'h456);
      wr(`OFS_SHAPE, 32'h0000_0003);
      rd(`OFS_SHAPE, 32'h0000_0003);
      // knee storage, out-of-range select ignored
      wr(`OFS_KNEE_SEL, 32'h0000_0003);
      rd(`OFS_KNEE_IN, 32'h0000_07fe);
      wr(`OFS_KNEE_IN, 32'h0000_0123);
      rd(`OFS_KNEE_IN, 32'h0000_0123);
      wr(`OFS_KNEE_SEL, 32'h0000_0000);
      rd(`OFS_KNEE_IN, 32'h0000_0000);
      wr(`OFS_KNEE_SEL, 32'h0000_0005);
      rd(`OFS_KNEE_OUT, 32'h0000_0d52);
      // falling segment into knee 5, then refill the table from the knees
      wr(`OFS_KNEE_OUT, 32'h0000_0000);
      wr(`OFS_BUILD, 32'h0000_0001);
      rd(`OFS_STATUS, 32'h0000_0001);
      bad(1'b1, `OFS_ENTRY_VAL);
      idle(20000);
      px(12'h600, 12'h95a);
      px(12'hc00, 12'h548);
      px(12'haa8, 12'haa8);
      // free table at both ends of the code range
      wr(`OFS_SHAPE, 32'h0000_0004);
      wr(`OFS_ENTRY_SEL, 32'h0000_0fff);
      wr(`OFS_ENTRY_VAL, 32'h0000_0123);
      rd(`OFS_ENTRY_VAL, 32'h0000_0123);
      px(12'hfff, 12'h123);
      wr(`OFS_ENTRY_SEL, 32'h0000_0000);
      wr(`OFS_ENTRY_VAL, 32'h0000_00a5);
      px(12'h000, 12'h0a5);
      // save, then read the persistent copy back
      wr(`OFS_PERSIST, 32'h0000_0001);
      rd(`OFS_STATUS, 32'h0000_0002);
      idle(2000);
      rd(`OFS_SAVED_VAL, 32'h0000_00a5);
      wr(`OFS_ENTRY_SEL, 32'h0000_0fff);
      rd(`OFS_SAVED_VAL, 32'h0000_0123);
      wr(`OFS_ENTRY_SEL, 32'h0000_0600);
      rd(`OFS_SAVED_VAL, 32'h0000_095a);
      bad(1'b0, 8'h30);
      bad(1'b1, `OFS_STATUS);
      bad(1'b0, `OFS_BUILD);
      give_verdict;
   end
endmodule
`default_nettype wire
